// File: core/epm_pkg.sv
/*
 * Shared constants and types for the enclave performance-monitoring
 * event control block.
 * Assumes a single core clock domain; no software-visible registers.
 */
package epm_pkg;

  localparam int ADDR_W          = 64;
  localparam int NUM_CTR         = 8;
  localparam int NUM_FIXED       = 3;
  // Position of the side-channel indicator in global counter status
  localparam int SCI_BIT         = 60;
  localparam logic SCI_RESET     = 1'b0;
  // Fixed counters that keep counting cycles under opt-out suppression
  localparam logic [2:0] FIXED_CYCLE_MASK = 3'h6;
  localparam logic [7:0] INC_ONE = 8'h01;

  typedef enum logic [2:0] {
    EV_NONE,
    EV_SUP_LEAF,
    EV_KEY_REPORT,
    EV_ENTER_RESUME,
    EV_EXIT_LEAF,
    EV_ASYNC_EXIT
  } enc_event_t;

  typedef enum logic [1:0] {
    STORE_OK,
    STORE_FAULT,
    STORE_TRAP
  } store_status_t;

endpackage

// File: core/epm_rec_if.sv
/*
 * Carrier between the control core and its eventing address selector.
 * Assumes both ends run on core_clk.
 */
`timescale 1ns/1ns
interface epm_rec_if;
  logic                       in_enclave;
  logic                       opt_out;
  logic [epm_pkg::ADDR_W-1:0] entry_addr;
  epm_pkg::enc_event_t        ev;
  logic [epm_pkg::ADDR_W-1:0] instr_addr;
  logic [epm_pkg::ADDR_W-1:0] ssa_ip;
  logic [epm_pkg::ADDR_W-1:0] aep_addr;
  logic                       eee_done;
  logic                       rec_valid;
  logic [epm_pkg::ADDR_W-1:0] rec_addr;

  modport ctrl (output in_enclave, opt_out, entry_addr, ev, instr_addr,
                ssa_ip, aep_addr, eee_done, input rec_valid, rec_addr);
  modport sel  (input in_enclave, opt_out, entry_addr, ev, instr_addr,
                ssa_ip, aep_addr, eee_done, output rec_valid, rec_addr);
endinterface

// File: core/epm_addr_sel.sv
/*
 * Eventing address selection for precise sampling records taken at
 * the end of enclave instructions and exits.
 * Assumes the control core presents one retiring event per cycle.
 */
`timescale 1ns/1ns
module epm_addr_sel (
  epm_rec_if.sel  rif,
  input  wire logic pend
);
  wire logic sup   = rif.ev == epm_pkg::EV_SUP_LEAF;
  wire logic keyr  = rif.ev == epm_pkg::EV_KEY_REPORT;
  wire logic entr  = rif.ev == epm_pkg::EV_ENTER_RESUME;
  wire logic exl   = rif.ev == epm_pkg::EV_EXIT_LEAF;
  wire logic async_enclave_exit   = rif.ev == epm_pkg::EV_ASYNC_EXIT;

  // Opt-out entry completes with sampling suppressed, and leaves run
  // inside an opt-out enclave record nothing until the exit
  wire logic quiet = rif.in_enclave & rif.opt_out;
  assign rif.rec_valid = pend & (((sup | keyr) & ~quiet) | exl | async_enclave_exit
                         | rif.eee_done | (entr & ~rif.opt_out));

  assign rif.rec_addr =
    rif.eee_done                ? rif.aep_addr :
    (sup | keyr | entr)         ? rif.instr_addr :
    (exl & rif.opt_out)         ? rif.entry_addr :
    exl                         ? rif.instr_addr :
    (async_enclave_exit & rif.opt_out)         ? rif.entry_addr :
                                  rif.ssa_ip;
endmodule

// File: core/enclave_perfmon_event_control.sv
/*
 * Per-thread control coordinating counters and precise sampling with
 * enclave entry and exit: suppression, sibling scope, eventing
 * address, record store faults and retirement increments.
 * Assumes retirement logic pulses one event per cycle, synchronous.
 */
`timescale 1ns/1ns

//------------------------------------------------------------
// Operation
//------------------------------------------------------------
// Operation
// - Exit resumes all suppressed monitoring and sampling
// - Exit restores sibling counters to all threads
// - Supervisor leaves report their own address
// - Key-get and report leaves report instruction address
// - Opt-in entry reports address; opt-out suppresses
// - Exit leaf record address depends on mode
// - Async exit record uses saved or entry address
// - Second record after exiting event uses pointer
// - Outside async exit, store faults deliver immediately
// - Async exit store faults hidden, record aborted
// - Async exit store traps pend to boundary
// - Exiting event delivery continues after abort
// - Opt-in transitions add one far branch
// - Opt-in transitions count as retired instructions
// - Opt-out enclave counts as one branch
// - Opt-out enclave counts as one instruction
// - Shared counters untouched by enclave entry
// - Opt-out stops thread counters except cycle fixed
// - Side-channel indicator set only under suppression
// - Opt-in leaves monitoring fully normal
module enclave_perfmon_event_control #(
  parameter int ADDR_W  = epm_pkg::ADDR_W,
  parameter int NUM_CTR = epm_pkg::NUM_CTR
) (
  // Clock, reset, enable
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  input  wire logic                clk_en,
  // Retirement events
  input  wire epm_pkg::enc_event_t ev,
  input  wire logic                ev_opt_out,
  input  wire logic [ADDR_W-1:0]   instr_addr,
  input  wire logic [ADDR_W-1:0]   ssa_ip,
  input  wire logic [ADDR_W-1:0]   aep_addr,
  input  wire logic                eee_done,
  input  wire logic                sample_pending,
  // Counter configuration
  input  wire logic [NUM_CTR-1:0]  ctr_branch,
  input  wire logic [NUM_CTR-1:0]  ctr_instr,
  input  wire logic [NUM_CTR-1:0]  sib_all_threads_count,
  // Record store status
  input  wire epm_pkg::store_status_t store_status,
  input  wire logic                store_in_aex,
  // Sampling record
  output logic                     rec_valid,
  output logic [ADDR_W-1:0]        eventing_address,
  // Counter control
  output logic                     pmc_suppress,
  output logic [2:0]               fixed_suppress,
  output logic                     sampling_suppress,
  output logic [NUM_CTR-1:0]       sib_own_thread_count,
  output logic [NUM_CTR-1:0]       ctr_inc,
  output logic                     shared_ctr_hold,
  output logic                     side_channel_indicator,
  // Store fault handling
  output logic                     fault_deliver,
  output logic                     record_abort,
  output logic                     trap_pending,
  output logic                     eee_continue
);

  //------------------------------------------------------------
  // Entry state
  //------------------------------------------------------------
  typedef enum {ST_OUT, ST_IN_OPTIN, ST_IN_OPTOUT} enc_state_t;
  enc_state_t state;
  enc_state_t next_state;
  logic [ADDR_W-1:0] entry_addr;

  wire logic is_enter = ev == epm_pkg::EV_ENTER_RESUME;
  wire logic is_exit  = ev == epm_pkg::EV_EXIT_LEAF ||
                        ev == epm_pkg::EV_ASYNC_EXIT;
  wire logic opt_out  = state == ST_IN_OPTOUT;
  wire logic in_encl  = state != ST_OUT;

  function automatic logic [NUM_CTR-1:0] sel_mask(
    input logic              en,
    input logic [NUM_CTR-1:0] m);
    sel_mask = en ? m : '0;
  endfunction

  always_comb begin
    next_state = state;
    case (state)
      ST_OUT: begin
        if (is_enter)
          next_state = ev_opt_out ? ST_IN_OPTOUT : ST_IN_OPTIN;
      end
      ST_IN_OPTIN, ST_IN_OPTOUT: begin
        if (is_exit)
          next_state = ST_OUT;
      end
      default: next_state = ST_OUT;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state      <= ST_OUT;
      entry_addr <= '0;
    end else if (clk_en) begin
      state <= next_state;
      if (is_enter && state == ST_OUT)
        entry_addr <= instr_addr;
    end
  end

  //------------------------------------------------------------
  // Eventing address selection
  //------------------------------------------------------------
  epm_rec_if rif ();
  assign rif.in_enclave = in_encl;
  // On entry the mode comes from the event itself
  assign rif.opt_out    = is_enter ? ev_opt_out : opt_out;
  assign rif.entry_addr = entry_addr;
  assign rif.ev         = ev;
  assign rif.instr_addr = instr_addr;
  assign rif.ssa_ip     = ssa_ip;
  assign rif.aep_addr   = aep_addr;
  assign rif.eee_done   = eee_done;

  epm_addr_sel u_sel (
    .rif  (rif.sel),
    .pend (sample_pending)
  );

  //------------------------------------------------------------
  // Suppression and retirement increments
  //------------------------------------------------------------
  wire logic next_sup = next_state == ST_IN_OPTOUT;
  wire logic optin_tr = (is_enter && !ev_opt_out && state == ST_OUT) ||
                        (is_exit && state == ST_IN_OPTIN);
  // Whole opt-out run is one branch and one instruction, credited at exit
  wire logic optout_x = is_exit && state == ST_IN_OPTOUT;
  wire logic one_inc  = optin_tr || optout_x;
  wire logic [NUM_CTR-1:0] next_inc =
    sel_mask(one_inc, ctr_branch) |
    sel_mask(one_inc, ctr_instr);

  // Fault on record store: hidden at end of async exit, else delivered
  wire logic st_fault = store_status == epm_pkg::STORE_FAULT;
  wire logic st_trap  = store_status == epm_pkg::STORE_TRAP;
  wire logic boundary = ev != epm_pkg::EV_NONE;
  // Either kind of store fault aborts the record in flight
  wire logic aex_fault = st_fault && store_in_aex;
  wire logic now_fault = st_fault && !store_in_aex;
  // A trap found after async exit waits for the next boundary
  wire logic trap_set  = st_trap && store_in_aex;

  // Cycle-counting fixed counters keep running under suppression
  wire logic [2:0] next_fixed = next_sup ? ~epm_pkg::FIXED_CYCLE_MASK
                                         : 3'h0;
  wire logic [NUM_CTR-1:0] next_sib =
    sel_mask(next_sup, sib_all_threads_count);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rec_valid              <= 1'b0;
      eventing_address       <= '0;
      pmc_suppress           <= 1'b0;
      fixed_suppress         <= 3'h0;
      sampling_suppress      <= 1'b0;
      sib_own_thread_count   <= '0;
      ctr_inc                <= '0;
      shared_ctr_hold        <= 1'b0;
      side_channel_indicator <= epm_pkg::SCI_RESET;
      fault_deliver          <= 1'b0;
      record_abort           <= 1'b0;
      trap_pending           <= 1'b0;
      eee_continue           <= 1'b0;
    end else if (clk_en) begin
      rec_valid        <= rif.rec_valid;
      eventing_address <= rif.rec_addr;
      // Opt-in keeps everything running; opt-out stops thread counters
      pmc_suppress      <= next_sup;
      fixed_suppress    <= next_fixed;
      sampling_suppress <= next_sup;
      sib_own_thread_count <= next_sib;
      ctr_inc           <= next_inc;
      shared_ctr_hold   <= 1'b0;
      side_channel_indicator <= next_sup;
      fault_deliver <= now_fault;
      record_abort  <= st_fault;
      eee_continue  <= aex_fault;
      if (trap_set)
        trap_pending <= 1'b1;
      else if (boundary)
        trap_pending <= 1'b0;
    end
  end

  //------------------------------------------------------------
  // Checks: exit, suppression and scope
  //------------------------------------------------------------
  a_exit_unsup: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && is_exit && in_encl |=> !sampling_suppress && !pmc_suppress)
    else $error("suppression kept after exit");
  a_sib_restore: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && is_exit |=> sib_own_thread_count == '0)
    else $error("sibling scope not restored");
  a_exit_fixed: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && is_exit |=> fixed_suppress == 3'h0 && !side_channel_indicator)
    else $error("fixed counters held after exit");
  a_optout_stop: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && is_enter && ev_opt_out && state == ST_OUT |=>
    pmc_suppress && sampling_suppress
    && fixed_suppress == ~epm_pkg::FIXED_CYCLE_MASK)
    else $error("opt-out entry left monitoring on");
  a_sib_narrow: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && next_state == ST_IN_OPTOUT |=>
    sib_own_thread_count == $past(sib_all_threads_count))
    else $error("sibling counters not narrowed");
  a_optin_norm: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && is_enter && !ev_opt_out && state == ST_OUT |=>
    !pmc_suppress && !sampling_suppress && fixed_suppress == 3'h0)
    else $error("opt-in entry suppressed monitoring");
  a_sci_track: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && is_enter && state == ST_OUT |=>
    side_channel_indicator == $past(ev_opt_out))
    else $error("indicator mismatch");
  a_sci_clear: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && state == ST_OUT && !is_enter |=> !side_channel_indicator)
    else $error("indicator set outside enclave");
  a_shared_free: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && is_enter |=> !shared_ctr_hold)
    else $error("shared counters held on entry");
  a_entry_keep: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && is_enter && state == ST_OUT |=>
    entry_addr == $past(instr_addr))
    else $error("entry address not kept");

  //------------------------------------------------------------
  // Checks: records and eventing address
  //------------------------------------------------------------
  a_sup_addr: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && ev == epm_pkg::EV_SUP_LEAF && sample_pending && !eee_done
    && !opt_out |=> rec_valid && eventing_address == $past(instr_addr))
    else $error("wrong supervisor leaf address");
  a_key_addr: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && ev == epm_pkg::EV_KEY_REPORT && sample_pending && !eee_done
    && !opt_out |=> rec_valid && eventing_address == $past(instr_addr))
    else $error("wrong key or report leaf address");
  a_optout_quiet: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && opt_out && !is_exit && !is_enter && !eee_done |=> !rec_valid)
    else $error("record inside opt-out enclave");
  a_optout_norec: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && is_enter && ev_opt_out && !eee_done |=> !rec_valid)
    else $error("record on opt-out entry");
  a_enter_addr: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && is_enter && !ev_opt_out && sample_pending && !eee_done
    |=> rec_valid && eventing_address == $past(instr_addr))
    else $error("wrong opt-in entry address");
  a_exit_addr: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && ev == epm_pkg::EV_EXIT_LEAF && opt_out && sample_pending
    && !eee_done |=> rec_valid && eventing_address == $past(entry_addr))
    else $error("wrong exit leaf address");
  a_exit_optin: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && ev == epm_pkg::EV_EXIT_LEAF && !opt_out && sample_pending
    && !eee_done |=> rec_valid && eventing_address == $past(instr_addr))
    else $error("wrong opt-in exit leaf address");
  a_aex_ssa: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && ev == epm_pkg::EV_ASYNC_EXIT && state == ST_IN_OPTIN
    && sample_pending && !eee_done |=> eventing_address == $past(ssa_ip))
    else $error("wrong async exit address");
  a_aex_entry: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && ev == epm_pkg::EV_ASYNC_EXIT && opt_out && sample_pending
    && !eee_done |=> rec_valid && eventing_address == $past(entry_addr))
    else $error("wrong opt-out async exit address");
  a_eee_aep: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && eee_done && sample_pending |=>
    rec_valid && eventing_address == $past(aep_addr))
    else $error("wrong second record address");
  a_no_pend: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && !sample_pending |=> !rec_valid)
    else $error("record without pending event");

  //------------------------------------------------------------
  // Checks: increments and store faults
  //------------------------------------------------------------
  a_optin_inc: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && optin_tr |=>
    ctr_inc == ($past(ctr_branch) | $past(ctr_instr)))
    else $error("opt-in transition not counted");
  a_optout_inc: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && optout_x |=>
    ctr_inc == ($past(ctr_branch) | $past(ctr_instr)))
    else $error("opt-out run not counted once");
  a_optout_entry: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && is_enter && ev_opt_out |=> ctr_inc == '0)
    else $error("opt-out entry counted");
  a_idle_noinc: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && !is_enter && !is_exit |=> ctr_inc == '0)
    else $error("increment without transition");
  a_fault_now: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && now_fault |=> fault_deliver && record_abort && !eee_continue)
    else $error("store fault not delivered");
  a_fault_hide: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && aex_fault |=> !fault_deliver && record_abort && eee_continue)
    else $error("async exit fault reported");
  a_cont_aex: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && !aex_fault |=> !eee_continue)
    else $error("exiting event resumed without abort");
  a_trap_pend: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && trap_set |=> trap_pending && !fault_deliver)
    else $error("store trap not held");
  a_trap_clear: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && boundary && !trap_set |=> !trap_pending)
    else $error("store trap held past boundary");

endmodule

// File: verification/epm_retire_model.sv
/*
 * Retirement and enclave-transition side of the event control block.
 * Assumes the bench calls retire at the falling edge of core_clk.
 */
`timescale 1ns/1ns
module epm_retire_model (
  // Retiring event toward the block
  output epm_pkg::enc_event_t ev,
  output logic                ev_opt_out,
  output logic                eee_done,
  // Addresses of the retiring event
  output logic [63:0]         instr_addr,
  output logic [63:0]         ssa_ip,
  output logic [63:0]         aep_addr
);
  initial begin
    ev = epm_pkg::EV_NONE;
    ev_opt_out = 1'h0;
    eee_done = 1'h0;
    instr_addr = 64'h0;
    ssa_ip = 64'h0;
    aep_addr = 64'h0;
  end

  // Idle cycles flip the address so a stale value never matches
  task automatic retire(input epm_pkg::enc_event_t e, input bit o, d,
                        input logic [63:0] ia, sp, ap);
    ev = e;
    ev_opt_out = o;
    eee_done = d;
    instr_addr = (e == epm_pkg::EV_NONE) ? ~instr_addr : ia;
    ssa_ip = sp;
    aep_addr = ap;
  endtask
endmodule

// File: verification/enclave_perfmon_event_control_bench.sv
/*
 * Self-checking bench: a behavioural model predicts every output.
 * Assumes one event per cycle, answers one cycle after the edge.
 */
`timescale 1ns/1ns
module enclave_perfmon_event_control_bench;
  logic                    core_clk, rst_b, clk_en, eee_done, ev_opt_out;
  logic                    sample_pending, store_in_aex, rec_valid;
  logic                    pmc_suppress, sampling_suppress, shared_ctr_hold;
  logic                    side_channel_indicator, fault_deliver;
  logic                    record_abort, trap_pending, eee_continue;
  epm_pkg::enc_event_t     ev;
  epm_pkg::store_status_t  store_status;
  logic [63:0]             instr_addr, ssa_ip, aep_addr, eventing_address;
  logic [7:0]              ctr_branch, ctr_instr, sib_all_threads_count;
  logic [7:0]              sib_own_thread_count, ctr_inc;
  logic [2:0]              fixed_suppress;
  int                      n_fail, cmp_count, i;
  integer                  seed, r;
  bit                      in_enc, oo, trap, e_rec, e_fd, e_ab, chk_inc, sup;
  bit [7:0]                e_inc;
  logic [63:0]             entry, e_addr;

  epm_retire_model u_ret (.ev(ev), .ev_opt_out(ev_opt_out),
    .eee_done(eee_done), .instr_addr(instr_addr), .ssa_ip(ssa_ip),
    .aep_addr(aep_addr));

  enclave_perfmon_event_control u_dut (.core_clk(core_clk), .rst_b(rst_b),
    .clk_en(clk_en), .ev(ev), .ev_opt_out(ev_opt_out),
    .instr_addr(instr_addr), .ssa_ip(ssa_ip), .aep_addr(aep_addr),
    .eee_done(eee_done), .sample_pending(sample_pending),
    .ctr_branch(ctr_branch), .ctr_instr(ctr_instr),
    .sib_all_threads_count(sib_all_threads_count),
    .store_status(store_status), .store_in_aex(store_in_aex),
    .rec_valid(rec_valid), .eventing_address(eventing_address),
    .pmc_suppress(pmc_suppress), .fixed_suppress(fixed_suppress),
    .sampling_suppress(sampling_suppress),
    .sib_own_thread_count(sib_own_thread_count), .ctr_inc(ctr_inc),
    .shared_ctr_hold(shared_ctr_hold),
    .side_channel_indicator(side_channel_indicator),
    .fault_deliver(fault_deliver), .record_abort(record_abort),
    .trap_pending(trap_pending), .eee_continue(eee_continue));

  initial begin
    core_clk = 1'h0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic check(input logic [63:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic verify();
    sup = in_enc && oo;
    check(rec_valid, e_rec);
    if (e_rec) check(eventing_address, e_addr);
    if (chk_inc) check(ctr_inc, e_inc);
    check(pmc_suppress, sup);
    check(sampling_suppress, sup);
    check(fixed_suppress, {2'h0, sup});
    check(side_channel_indicator, sup);
    check(sib_own_thread_count,
          sup ? sib_all_threads_count : 8'h00);
    check(shared_ctr_hold, 1'h0);
    check(fault_deliver, e_fd);
    check(record_abort, e_ab);
    check(trap_pending, trap);
    if (e_ab && !e_fd) check(eee_continue, 1'h1);
  endtask

  // Checks the previous cycle, then presents one event
  task automatic step(input epm_pkg::enc_event_t e, input bit o = 0,
      p = 1, d = 0, input epm_pkg::store_status_t s = epm_pkg::STORE_OK,
      input bit a = 0);
    logic [63:0] ia, sp, ap;
    ia = {$random(seed), $random(seed)};
    sp = {$random(seed), $random(seed)};
    ap = {$random(seed), $random(seed)};
    @(negedge core_clk);
    verify();
    u_ret.retire(e, o, d, ia, sp, ap);
    sample_pending = p;
    store_status = s;
    store_in_aex = a;
    ctr_branch = sp[7:0];
    ctr_instr = ap[7:0];
    e_rec = 0;
    e_inc = 8'h00;
    e_addr = ia;
    chk_inc = 1;
    e_fd = s == epm_pkg::STORE_FAULT && !a;
    e_ab = s == epm_pkg::STORE_FAULT;
    if (e != epm_pkg::EV_NONE) trap = 0;
    if (s == epm_pkg::STORE_TRAP && a) trap = 1;
    case (e)
      epm_pkg::EV_SUP_LEAF, epm_pkg::EV_KEY_REPORT: begin
        e_rec = p && !(in_enc && oo);
        chk_inc = 0;
      end
      epm_pkg::EV_ENTER_RESUME: begin
        sib_all_threads_count = ia[15:8];
        in_enc = 1;
        oo = o;
        entry = ia;
        e_rec = p && !o;
        e_inc = o ? 8'h00 : sp[7:0] | ap[7:0];
      end
      epm_pkg::EV_EXIT_LEAF, epm_pkg::EV_ASYNC_EXIT: begin
        e_rec = p;
        e_inc = sp[7:0] | ap[7:0];
        if (oo) e_addr = entry;
        else if (e == epm_pkg::EV_ASYNC_EXIT) e_addr = sp;
        in_enc = 0;
      end
      default: if (d) begin
        e_rec = p;
        e_addr = ap;
      end
    endcase
  endtask

  // Clock enable low for one edge: outputs must hold, event not retaken
  task automatic freeze();
    @(negedge core_clk);
    clk_en = 1'h0;
    step(epm_pkg::EV_NONE, 0, 0);
    clk_en = 1'h1;
  endtask

  initial begin
    seed = 32'h87F7;
    rst_b = 1'h0;
    clk_en = 1'h1;
    sample_pending = 1'h0;
    store_status = epm_pkg::STORE_OK;
    store_in_aex = 1'h0;
    {ctr_branch, ctr_instr, sib_all_threads_count} = 24'h0;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk) rst_b = 1'h1;
    step(epm_pkg::EV_SUP_LEAF);
    step(epm_pkg::EV_KEY_REPORT);
    step(epm_pkg::EV_ENTER_RESUME);
    freeze();
    step(epm_pkg::EV_KEY_REPORT);
    step(epm_pkg::EV_EXIT_LEAF);
    step(epm_pkg::EV_ENTER_RESUME, 1);
    step(epm_pkg::EV_KEY_REPORT);
    step(epm_pkg::EV_NONE, 0, 0);
    step(epm_pkg::EV_EXIT_LEAF);
    step(epm_pkg::EV_ENTER_RESUME, 0, 0);
    step(epm_pkg::EV_ASYNC_EXIT);
    step(epm_pkg::EV_NONE, 0, 0, 0, epm_pkg::STORE_FAULT, 1);
    step(epm_pkg::EV_NONE, 0, 1, 1);
    step(epm_pkg::EV_ENTER_RESUME, 1, 0);
    step(epm_pkg::EV_ASYNC_EXIT);
    step(epm_pkg::EV_NONE, 0, 0, 0, epm_pkg::STORE_TRAP, 1);
    step(epm_pkg::EV_NONE, 0, 0);
    step(epm_pkg::EV_SUP_LEAF, 0, 0);
    step(epm_pkg::EV_NONE, 0, 0, 0, epm_pkg::STORE_FAULT, 0);
    for (i = 0; i < 300; i++) begin
      r = $random(seed);
      if (in_enc) step(r[0] ? epm_pkg::EV_EXIT_LEAF
                            : epm_pkg::EV_ASYNC_EXIT, r[1], r[2]);
      else step(r[0] ? epm_pkg::EV_ENTER_RESUME
                     : epm_pkg::EV_SUP_LEAF, r[1], r[2]);
    end
    step(epm_pkg::EV_NONE, 0, 0);
    conclude();
  end

  // Whole run is about 1340 ns; this bound only cuts a hang
  initial begin
    #40000;
    n_fail++;
    conclude();
  end
endmodule
